// ==== verilog/acq_qualifier.sv ====
// store qualification and run control for a state logic analyser
// Behaviour
// - sample target bus every state cycle while running
// - no qualify anywhere stores every sample
// - global store block evaluated every running cycle
// - with qualify, store on block or command
// - store command overrides false block event
// - block event is OR of optionally inverted events
// - one store block, any number of commands
// - unstored trigger marks last stored or first
// - store decision never moves the sampling instant
// - store with trigger keeps the trigger word
// - start checks program, runs from test one
// - start/stop while running halts, enters display
// - missing final terminator appended on clean start
// - faulty program raises error, stays stopped
// - programs run only from program memory
// - copy to storage swaps when storage holds program
// - storage to program errors when empty, returns
// - transfers wait for explicit execute confirmation
// - display storage acts at once, display mode
// - post-trigger delay counts stored words only
`timescale 1ns/1ps
`include "analyser_map.svh"
module acq_qualifier #(
  parameter int FIFO_DEPTH = `FIFO_DEPTH,
  parameter int ADDR_W     = `ADDR_W
) (
  input  wire logic                          ref_clk,
  input  wire logic                          sys_rst,
  input  wire logic                          state_clk_pin,
  input  wire logic [`DATA_W-1:0]            bus_pin,
  input  wire analyser_pkg::cmd_t            cmd,
  input  wire logic                          prog_load,
  input  wire analyser_pkg::program_t        prog_load_data,
  input  wire analyser_pkg::test_result_t    test_res,
  input  wire logic                          acq_ready,
  output analyser_pkg::mode_t                mode,
  output logic [`TEST_W-1:0]                 active_test,
  output logic                               sample_tick,
  output logic [`DATA_W-1:0]                 sample_word,
  output logic                               acq_wr,
  output logic [ADDR_W-1:0]                  acq_addr,
  output analyser_pkg::sample_t              acq_data,
  output logic [ADDR_W-1:0]                  trig_mark,
  output logic                               trig_valid,
  output logic                               error,
  output logic                               overflow,
  output logic                               storage_has_prog
);
  import analyser_pkg::*;

  generate
    if (ADDR_W != `ADDR_W) begin : g_bad_addr
      $error("acq_qualifier address width must match the delay field");
    end
  endgenerate

  // pin synchronisers, three stages each
  logic               clk_s1;
  logic               clk_s2;
  logic               clk_s3;
  logic               clk_level;
  logic [`DATA_W-1:0] bus_s1;
  logic [`DATA_W-1:0] bus_s2;
  logic [`DATA_W-1:0] bus_s3;

  // program side state
  program_t           prog_mem;
  program_t           store_mem;
  mode_t              prev_mode;
  pend_t              pend;

  // acquisition state
  logic               triggered;
  logic               stored_any;
  logic [ADDR_W-1:0]  push_cnt;
  logic [ADDR_W-1:0]  post_cnt;

  // combinational decisions
  logic               state_edge;
  logic               running;
  logic               run_cycle;
  logic               blk_event;
  logic               store_now;
  logic               push;
  logic               trig_now;
  logic               acq_done;
  logic               fault;
  logic               start_req;
  logic               start_ok;
  logic               start_err;
  logic               stop_req;
  logic               exec_p2s;
  logic               exec_s2p;
  logic               s2p_err;
  logic               fifo_in_ready;
  logic               fifo_out_valid;
  sample_t            fifo_in_data;
  sample_t            fifo_out_data;

  // a level is accepted only when the second and third stages agree
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_s1    <= 1'b0;
      clk_s2    <= 1'b0;
      clk_s3    <= 1'b0;
      clk_level <= 1'b0;
      bus_s1    <= '0;
      bus_s2    <= '0;
      bus_s3    <= '0;
    end else begin
      clk_s1 <= state_clk_pin;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      bus_s1 <= bus_pin;
      bus_s2 <= bus_s1;
      bus_s3 <= bus_s2;
      if (clk_s2 == clk_s3) begin
        clk_level <= clk_s3;
      end
    end
  end

  assign state_edge = (clk_s2 == clk_s3) && clk_s3 && !clk_level;
  assign running    = mode == MODE_RUN;

  // the state clock alone fixes when a word is taken
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sample_tick <= 1'b0;
      sample_word <= '0;
    end else begin
      sample_tick <= state_edge && running;
      if (state_edge && running) begin
        sample_word <= bus_s3;
      end
    end
  end

  // results for the word on sample_word arrive while sample_tick is high
  assign run_cycle = sample_tick && running;

  // the single block lives in program memory, commands come per cycle
  assign blk_event = |((test_res.events ^ prog_mem.blk_inv) & prog_mem.blk_sel);

  // decided in the tick cycle itself, no later results used
  always_comb begin
    store_now = 1'b0;
    if (run_cycle) begin
      if (!prog_mem.uses_qualify) begin
        store_now = 1'b1;
      end else begin
        store_now = (prog_mem.has_qual_blk && blk_event)
                    || test_res.store_cmd;
      end
    end
  end

  // a full buffer loses the word; the target cannot be stalled
  assign push     = store_now && fifo_in_ready;
  assign trig_now = run_cycle && test_res.trigger_cmd && !triggered;
  assign acq_done = running && prog_mem.has_trigger && triggered
                    && post_cnt == prog_mem.delay;

  assign fifo_in_data.word = sample_word;
  assign fifo_in_data.trig = trig_now;

  sample_fifo #(
    .W     ($bits(sample_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .in_valid  (store_now),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (acq_ready),
    .out_data  (fifo_out_data)
  );

  // acquisition memory write port, drained as the memory allows
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      acq_wr   <= 1'b0;
      acq_addr <= '0;
      acq_data <= '0;
    end else begin
      acq_wr <= fifo_out_valid && acq_ready;
      if (fifo_out_valid && acq_ready) begin
        acq_data <= fifo_out_data;
      end
      if (acq_wr) begin
        acq_addr <= acq_addr + `ADDR_ONE;
      end
      if (start_ok) begin
        acq_addr <= `ADDR_ZERO;
      end
    end
  end

  // trigger marker and post-trigger count, kept in push order
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      triggered  <= 1'b0;
      stored_any <= 1'b0;
      push_cnt   <= '0;
      post_cnt   <= '0;
      trig_mark  <= '0;
      trig_valid <= 1'b0;
      overflow   <= 1'b0;
    end else if (start_ok) begin
      triggered  <= 1'b0;
      stored_any <= 1'b0;
      push_cnt   <= '0;
      post_cnt   <= '0;
      trig_mark  <= '0;
      trig_valid <= 1'b0;
      overflow   <= 1'b0;
    end else begin
      if (push) begin
        push_cnt   <= push_cnt + `ADDR_ONE;
        stored_any <= 1'b1;
      end
      if (store_now && !fifo_in_ready) begin
        overflow <= 1'b1;
      end
      if (push && triggered) begin
        post_cnt <= post_cnt + `ADDR_ONE;
      end
      if (trig_now) begin
        triggered  <= 1'b1;
        trig_valid <= 1'b1;
        if (push) begin
          trig_mark <= push_cnt;
        end else if (stored_any) begin
          trig_mark <= push_cnt - `ADDR_ONE;
        end else begin
          trig_mark <= `ADDR_ZERO;
        end
      end
    end
  end

  // start, stop and transfer decisions
  assign fault     = prog_mem.contradictory || prog_mem.incomplete;
  assign start_req = cmd.start_stop && !running;
  assign start_ok  = start_req && !fault;
  assign start_err = start_req && fault;
  assign stop_req  = running && (cmd.start_stop || acq_done);
  assign exec_p2s  = mode == MODE_IMMED && cmd.execute && pend == PEND_P2S;
  assign exec_s2p  = mode == MODE_IMMED && cmd.execute && pend == PEND_S2P;
  assign s2p_err   = exec_s2p && !storage_has_prog;

  // program and storage memories
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prog_mem         <= '0;
      store_mem        <= '0;
      storage_has_prog <= 1'b0;
    end else begin
      if (prog_load && mode == MODE_PROG) begin
        prog_mem <= prog_load_data;
      end
      if (start_ok && !prog_mem.terminated) begin
        prog_mem.terminated <= 1'b1;
      end
      if (exec_p2s) begin
        store_mem        <= prog_mem;
        storage_has_prog <= 1'b1;
        if (storage_has_prog) begin
          prog_mem <= store_mem;
        end
      end
      if (exec_s2p && storage_has_prog) begin
        prog_mem <= store_mem;
      end
    end
  end

  // operating mode and pending immediate command
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode      <= MODE_PROG;
      prev_mode <= MODE_PROG;
      pend      <= PEND_NONE;
    end else begin
      unique case (mode)
        MODE_RUN: begin
          if (stop_req) begin
            mode <= MODE_DISPLAY;
          end
        end
        MODE_IMMED: begin
          if (start_ok) begin
            mode <= MODE_RUN;
            pend <= PEND_NONE;
          end else if (cmd.display_store) begin
            mode <= MODE_DISPLAY;
            pend <= PEND_NONE;
          end else if (cmd.show_program) begin
            mode <= MODE_PROG;
            pend <= PEND_NONE;
          end else if (cmd.execute && pend != PEND_NONE) begin
            mode <= prev_mode;
            pend <= PEND_NONE;
          end else if (cmd.req_p2s) begin
            pend <= PEND_P2S;
          end else if (cmd.req_s2p) begin
            pend <= PEND_S2P;
          end else if (cmd.immediate) begin
            pend <= PEND_NONE;
          end
        end
        MODE_PROG, MODE_DISPLAY: begin
          if (start_ok) begin
            mode <= MODE_RUN;
          end else if (cmd.immediate) begin
            prev_mode <= mode;
            mode      <= MODE_IMMED;
            pend      <= PEND_NONE;
          end
        end
      endcase
    end
  end

  // active test: test one on start, then follow executed jumps
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      active_test <= `FIRST_TEST;
    end else if (start_ok) begin
      active_test <= `FIRST_TEST;
    end else if (run_cycle && test_res.goto_valid) begin
      active_test <= test_res.goto_test;
    end
  end

  // error is a single-cycle pulse per refused request
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      error <= 1'b0;
    end else begin
      error <= start_err || s2p_err;
    end
  end
endmodule : acq_qualifier

// ==== verilog/analyser_map.svh ====
// constants for the acquisition qualifier and run control
`ifndef ANALYSER_MAP_SVH
`define ANALYSER_MAP_SVH
`define DATA_W      16
`define EV_N        4
`define TEST_W      3
`define ADDR_W      8
`define FIFO_DEPTH  8
`define FIRST_TEST  3'h1
`define ADDR_ZERO   8'h00
`define ADDR_ONE    8'h01
`endif

// ==== verilog/analyser_pkg.sv ====
// types shared by the acquisition qualifier and run control
package analyser_pkg;
`include "analyser_map.svh"

  typedef enum logic [1:0] {
    MODE_PROG    = 2'b00,
    MODE_DISPLAY = 2'b01,
    MODE_IMMED   = 2'b10,
    MODE_RUN     = 2'b11
  } mode_t;

  typedef enum logic [1:0] {
    PEND_NONE = 2'b00,
    PEND_P2S  = 2'b01,
    PEND_S2P  = 2'b10
  } pend_t;

  typedef struct packed {
    logic                 has_qual_blk;
    logic                 uses_qualify;
    logic [`EV_N-1:0]     blk_sel;
    logic [`EV_N-1:0]     blk_inv;
    logic                 has_trigger;
    logic [`ADDR_W-1:0]   delay;
    logic                 terminated;
    logic                 contradictory;
    logic                 incomplete;
  } program_t;

  typedef struct packed {
    logic start_stop;
    logic immediate;
    logic req_p2s;
    logic req_s2p;
    logic display_store;
    logic show_program;
    logic execute;
  } cmd_t;

  typedef struct packed {
    logic                 store_cmd;
    logic                 trigger_cmd;
    logic                 goto_valid;
    logic [`TEST_W-1:0]   goto_test;
    logic [`EV_N-1:0]     events;
  } test_result_t;

  typedef struct packed {
    logic [`DATA_W-1:0] word;
    logic               trig;
  } sample_t;

endpackage : analyser_pkg

// ==== verilog/sample_fifo.sv ====
// small first-in first-out buffer for stored samples
`timescale 1ns/1ps
module sample_fifo #(
  parameter int W     = 17,
  parameter int DEPTH = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
      $error("sample_fifo depth must be a power of two, at least 2");
    end
  endgenerate

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wp;
  logic [PW-1:0] rp;
  logic [PW:0]   cnt;
  logic          push;
  logic          pop;

  assign in_ready  = cnt != (PW+1)'(DEPTH);
  assign out_valid = cnt != '0;
  assign out_data  = mem[rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        wp <= wp + 1'b1;
      end
      if (pop) begin
        rp <= rp + 1'b1;
      end
      cnt <= cnt + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : sample_fifo

// ==== tb/acq_qualifier_monitor.sv ====
// concurrent checks on the ports of the acquisition qualifier
`timescale 1ns/1ps
module acq_qualifier_monitor #(
  parameter int FIFO_DEPTH = 8,
  parameter int ADDR_W     = 8
) (
  input wire logic                       ref_clk,
  input wire logic                       sys_rst,
  input wire analyser_pkg::cmd_t         cmd,
  input wire logic                       prog_load,
  input wire analyser_pkg::program_t     prog_load_data,
  input wire analyser_pkg::test_result_t test_res,
  input wire logic                       acq_ready,
  input wire analyser_pkg::mode_t        mode,
  input wire logic [2:0]                 active_test,
  input wire logic                       sample_tick,
  input wire logic                       acq_wr,
  input wire logic                       error,
  input wire logic                       storage_has_prog
);
  import analyser_pkg::*;
  program_t   shadow;
  logic       known;
  logic       stored;
  logic [7:0] pend;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      known  <= 1'b0;
      shadow <= '0;
    end else if (prog_load && mode == MODE_PROG) begin
      known  <= 1'b1;
      shadow <= prog_load_data;
    end else if (cmd.execute && mode == MODE_IMMED) begin
      known <= 1'b0; // a swap makes the shadow stale, so stop trusting it
    end
  end

  assign stored = sample_tick && (!known || !shadow.uses_qualify || test_res.store_cmd
    || (shadow.has_qual_blk && |((test_res.events ^ shadow.blk_inv) & shadow.blk_sel)));

  // words qualified but not yet written; lost words only loosen the bound
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend <= 8'h00;
    end else begin
      pend <= pend + {7'h00, stored} - {7'h00, acq_wr && pend != 8'h00};
    end
  end

  sequence s_store;
    sample_tick && test_res.store_cmd && acq_ready;
  endsequence
  sequence s_exec;
    mode == MODE_IMMED && $onehot(cmd) && cmd.execute;
  endsequence
  sequence s_s2p_empty;
    mode == MODE_IMMED && !storage_has_prog && $onehot(cmd) && cmd.req_s2p;
  endsequence
  sequence s_p2s;
    mode == MODE_IMMED && $onehot(cmd) && cmd.req_p2s;
  endsequence

  a_tick_only_run: assert property (sample_tick |-> $past(mode) == MODE_RUN)
    else $error("sample tick outside run");
  a_store_kept: assert property (s_store |-> ##[1:8] acq_wr or ##[1:8] !acq_ready)
    else $error("store command word not written");
  a_wr_qualified: assert property (acq_wr |-> pend != 8'h00)
    else $error("write without qualified sample");
  a_fault_refused: assert property (known && $onehot(cmd) && cmd.start_stop
    && mode == MODE_PROG && (shadow.contradictory || shadow.incomplete)
    |=> error && mode == MODE_PROG) else $error("faulty program not refused");
  a_clean_start: assert property (known && $onehot(cmd) && cmd.start_stop
    && mode == MODE_PROG && !shadow.contradictory && !shadow.incomplete
    |=> mode == MODE_RUN && active_test == 3'h1) else $error("clean start not running");
  a_stop_display: assert property ($onehot(cmd) && cmd.start_stop && mode == MODE_RUN
    |=> mode == MODE_DISPLAY) else $error("stop did not enter display");
  a_display_store: assert property ($onehot(cmd) && cmd.display_store
    && mode == MODE_IMMED |=> mode == MODE_DISPLAY) else $error("display store not at once");
  a_request_waits: assert property ($onehot(cmd) && (cmd.req_p2s || cmd.req_s2p)
    && mode == MODE_IMMED |=> mode == MODE_IMMED && !error) else $error("transfer not held");
  a_s2p_empty: assert property (s_s2p_empty ##3 s_exec |=> error && mode != MODE_IMMED)
    else $error("empty storage transfer not flagged");
  a_p2s_storage: assert property (s_p2s ##3 s_exec |=> storage_has_prog)
    else $error("storage not holding program");
endmodule : acq_qualifier_monitor

bind acq_qualifier acq_qualifier_monitor #(.FIFO_DEPTH(FIFO_DEPTH), .ADDR_W(ADDR_W))
  i_acq_qualifier_monitor (.ref_clk(ref_clk), .sys_rst(sys_rst), .cmd(cmd),
  .prog_load(prog_load), .prog_load_data(prog_load_data), .test_res(test_res),
  .acq_ready(acq_ready), .mode(mode), .active_test(active_test), .sample_tick(sample_tick),
  .acq_wr(acq_wr), .error(error), .storage_has_prog(storage_has_prog));

// ==== tb/sut_bus_model.sv ====
// model of the target bus and its qualified state clock
`timescale 1ns/1ps
module sut_bus_model #(
  parameter logic [15:0] BASE = 16'ha500
) (
  input  wire logic   ref_clk,
  input  wire logic   run_en,
  output logic        state_clk_pin,
  output logic [15:0] bus_pin
);
  logic [2:0]  phase;
  logic [15:0] count;
  logic [15:0] noise = 16'h5a3c;

  // high and low last four ref cycles each, twice the two-cycle minimum
  always @(posedge ref_clk) begin
    if (!run_en) begin
      phase <= 3'h0;
      count <= 16'h0000;
      state_clk_pin <= 1'b0;
      noise <= ~noise;
      bus_pin <= noise; // an idle bus keeps toggling so stale data never looks valid
    end else begin
      phase <= phase + 3'h1;
      bus_pin <= BASE + count;
      if (phase == 3'h3) state_clk_pin <= 1'b1;
      if (phase == 3'h7) begin
        state_clk_pin <= 1'b0;
        count <= count + 16'h0001;
      end
    end
  end
endmodule : sut_bus_model

// ==== tb/acq_qualifier_tb.sv ====
// self-checking bench for the acquisition qualifier and run control
`timescale 1ns/1ps
module acq_qualifier_tb;
  import analyser_pkg::*;
  localparam logic [15:0] word_base = 16'ha500;
  localparam logic [6:0] c_start = 7'h40, c_imm = 7'h20, c_p2s = 7'h10, c_s2p = 7'h08;
  localparam logic [6:0] c_dstore = 7'h04, c_show = 7'h02, c_exec = 7'h01;
  logic         ref_clk, sys_rst, state_clk_pin, prog_load, acq_ready, sut_en, err_seen;
  logic         sample_tick, acq_wr, trig_valid, error, overflow, storage_has_prog;
  logic [15:0]  bus_pin, sample_word;
  logic [2:0]   active_test;
  logic [7:0]   acq_addr, trig_mark;
  cmd_t         cmd;
  program_t     prog_load_data;
  test_result_t test_res;
  mode_t        mode;
  sample_t      acq_data;
  sample_t      wq[$];
  int           mismatches, check_count, nticks;

  acq_qualifier i_acq_qualifier (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .state_clk_pin(state_clk_pin), .bus_pin(bus_pin), .cmd(cmd), .prog_load(prog_load),
    .prog_load_data(prog_load_data), .test_res(test_res), .acq_ready(acq_ready),
    .mode(mode), .active_test(active_test), .sample_tick(sample_tick),
    .sample_word(sample_word), .acq_wr(acq_wr), .acq_addr(acq_addr), .acq_data(acq_data),
    .trig_mark(trig_mark), .trig_valid(trig_valid), .error(error), .overflow(overflow),
    .storage_has_prog(storage_has_prog));
  sut_bus_model #(.BASE(word_base)) i_sut_bus_model (.ref_clk(ref_clk), .run_en(sut_en),
    .state_clk_pin(state_clk_pin), .bus_pin(bus_pin));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  always @(negedge ref_clk) begin
    if (sample_tick === 1'b1) nticks++;
    if (acq_wr === 1'b1) wq.push_back(acq_data);
  end

  task automatic print_verdict();
    if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic cm(input mode_t m);
    check("mode", 16'(m), 16'(mode));
  endtask : cm

  // error is a one-cycle pulse, so it is caught on both cycles after the command
  task automatic pulse(input logic [6:0] c);
    @(negedge ref_clk);
    cmd = cmd_t'(c);
    @(negedge ref_clk);
    cmd = '0;
    err_seen = error;
    @(negedge ref_clk);
    err_seen = err_seen | error;
  endtask : pulse

  task automatic load(input program_t p);
    @(negedge ref_clk);
    prog_load = 1'b1;
    prog_load_data = p;
    @(negedge ref_clk);
    prog_load = 1'b0;
  endtask : load

  task automatic to_prog();
    pulse(c_imm);
    pulse(c_show);
  endtask : to_prog

  task automatic run_sut(input int n);
    int t0;
    int k;
    t0 = nticks;
    k = 0;
    sut_en = 1'b1;
    while (nticks < t0 + n && k < 20 * n) begin
      @(negedge ref_clk);
      k++;
    end
    sut_en = 1'b0;
    if (k >= 20 * n) begin
      mismatches++;
      print_verdict();
    end
    repeat (30) @(negedge ref_clk);
  endtask : run_sut

  task automatic t_transfer();
    program_t p;
    p = '0;
    load(p);
    pulse(c_imm);
    pulse(c_s2p);
    cm(MODE_IMMED);
    check("error", 16'h0, 16'(err_seen));
    pulse(c_exec);
    check("error", 16'h1, 16'(err_seen));
    cm(MODE_PROG);
    pulse(c_imm);
    pulse(c_p2s);
    check("storage_has_prog", 16'h0, 16'(storage_has_prog));
    pulse(c_exec);
    check("storage_has_prog", 16'h1, 16'(storage_has_prog));
    cm(MODE_PROG);
    p.contradictory = 1'b1;
    load(p);
    pulse(c_imm);
    pulse(c_p2s);
    pulse(c_exec);
    pulse(c_imm);
    pulse(c_dstore);
    cm(MODE_DISPLAY);
    to_prog();
    pulse(c_start);
    cm(MODE_RUN);
    pulse(c_start);
  endtask : t_transfer

  task automatic t_start_check();
    program_t p;
    to_prog();
    for (int i = 0; i < 2; i++) begin
      p = '0;
      p.contradictory = (i == 0);
      p.incomplete = (i == 1);
      load(p);
      pulse(c_start);
      check("error", 16'h1, 16'(err_seen));
      cm(MODE_PROG);
    end
    p = '0;
    load(p);
    pulse(c_start);
    check("error", 16'h0, 16'(err_seen));
    cm(MODE_RUN);
    check("active_test", 16'h1, 16'(active_test));
    pulse(c_start);
    cm(MODE_DISPLAY);
  endtask : t_start_check

  task automatic t_buffer();
    int t0;
    to_prog();
    load('0);
    acq_ready = 1'b0;
    pulse(c_start);
    wq.delete();
    t0 = nticks;
    run_sut(10);
    check("ticks", 16'h000a, 16'(nticks - t0));
    check("overflow", 16'h1, 16'(overflow));
    check("sample_word", word_base + 16'h0009, sample_word);
    acq_ready = 1'b1;
    repeat (30) @(negedge ref_clk);
    check("writes", 16'h0008, 16'(wq.size()));
    check("acq_addr", 16'h0008, 16'(acq_addr));
    for (int i = 0; i < 8; i++) check("word", word_base + 16'(i), wq[i].word);
    pulse(c_start);
  endtask : t_buffer

  task automatic t_qualify();
    program_t p;
    logic [5:0] cases [4];
    cases = '{6'b0010_0_0, 6'b0010_1_1, 6'b0001_0_1, 6'b1110_0_0};
    to_prog();
    p = '0;
    p.uses_qualify = 1'b1;
    p.has_qual_blk = 1'b1;
    p.blk_sel = 4'b0011;
    p.blk_inv = 4'b0010;
    load(p);
    pulse(c_start);
    for (int i = 0; i < 4; i++) begin
      test_res = '0;
      test_res.goto_valid = 1'b1; // the block must not care which test is active
      test_res.goto_test = 3'h2;
      test_res.events = cases[i][5:2];
      test_res.store_cmd = cases[i][1];
      wq.delete();
      run_sut(3);
      check("stored", cases[i][0] ? 16'h3 : 16'h0, 16'(wq.size()));
    end
    check("active_test", 16'h2, 16'(active_test));
    test_res = '0;
    pulse(c_start);
  endtask : t_qualify

  task automatic t_trigger();
    program_t p;
    to_prog();
    p = '0;
    p.uses_qualify = 1'b1;
    p.has_trigger = 1'b1;
    p.delay = 8'h02;
    load(p);
    pulse(c_start);
    wq.delete();
    test_res.trigger_cmd = 1'b1;
    run_sut(1);
    test_res = '0;
    check("trig_valid", 16'h1, 16'(trig_valid));
    check("trig_mark", 16'h0, 16'(trig_mark));
    run_sut(2);
    cm(MODE_RUN);
    test_res.store_cmd = 1'b1;
    run_sut(2);
    cm(MODE_DISPLAY);
    check("stored", 16'h2, 16'(wq.size()));
    to_prog();
    p.delay = 8'h00;
    load(p);
    pulse(c_start);
    wq.delete();
    test_res = '0;
    test_res.store_cmd = 1'b1;
    run_sut(2);
    test_res.trigger_cmd = 1'b1;
    run_sut(1);
    test_res = '0;
    check("trigger word", 16'h1, 16'(wq[2].trig));
    check("trig_mark", 16'h2, 16'(trig_mark));
    cm(MODE_DISPLAY);
    to_prog();
    load(p);
    pulse(c_start);
    test_res.store_cmd = 1'b1;
    run_sut(2);
    test_res.store_cmd = 1'b0;
    test_res.trigger_cmd = 1'b1;
    run_sut(1);
    test_res = '0;
    check("trig_mark", 16'h1, 16'(trig_mark));
    cm(MODE_DISPLAY);
  endtask : t_trigger

  initial begin
    sys_rst = 1'b1;
    cmd = '0;
    prog_load = 1'b0;
    prog_load_data = '0;
    test_res = '0;
    acq_ready = 1'b1;
    sut_en = 1'b0;
    err_seen = 1'b0;
    mismatches = 0;
    check_count = 0;
    nticks = 0;
    repeat (6) @(negedge ref_clk);
    sys_rst = 1'b0;
    cm(MODE_PROG);
    check("active_test", 16'h1, 16'(active_test));
    check("storage_has_prog", 16'h0, 16'(storage_has_prog));
    t_transfer();
    t_start_check();
    t_buffer();
    t_qualify();
    t_trigger();
    print_verdict();
  end
endmodule : acq_qualifier_tb
